/* File: rtl/rocu_pkg.sv */
// Shared constants and types of the recorder output command unit
package rocu_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CMD      = 8'h00;
  localparam logic [7:0] REG_ARG0     = 8'h04;
  localparam logic [7:0] REG_ARG1     = 8'h08;
  localparam logic [7:0] REG_RESULT   = 8'h0C;
  localparam logic [7:0] REG_SETTINGS = 8'h10;
  localparam logic [7:0] REG_MASK     = 8'h14;
  localparam logic [7:0] REG_IFACE    = 8'h18;
  localparam logic [7:0] REG_OWN_CONN = 8'h1C;
  localparam logic [7:0] REG_OWN_IP   = 8'h20;
  localparam logic [7:0] REG_DROPS    = 8'h24;

  // Field positions
  localparam int ARG0_LF_ONLY_BIT   = 8;
  localparam int ARG1_FIRST_LSB     = 0;
  localparam int ARG1_LAST_LSB      = 8;
  localparam int ARG1_COUNT_LSB     = 16;
  localparam int ARG1_COUNT_GIVEN   = 24;
  localparam int IFACE_ETH_BIT      = 0;
  localparam int IFACE_DOT_BIT      = 1;
  localparam int IFACE_ADDR_LSB     = 8;
  localparam int RESULT_DONE_BIT    = 8;
  localparam int RESULT_BUSY_BIT    = 9;
  localparam int SET_BYTE_ORDER_BIT = 0;
  localparam int SET_CHECKSUM_BIT   = 1;
  localparam int SET_UNIT_OPEN_BIT  = 2;

  // Reset values of the session settings
  localparam logic        BYTE_ORDER_RST = 1'b0;
  localparam logic        CHECKSUM_RST   = 1'b0;
  localparam logic [31:0] MASK_RST       = 32'hFFFFFFFF;

  // Response codes
  localparam logic [7:0] RESP_NONE   = 8'h00;
  localparam logic [7:0] RESP_OK     = 8'hE0;
  localparam logic [7:0] ERR_PARAM   = 8'h01;
  localparam logic [7:0] ERR_IFACE   = 8'h02;
  localparam logic [7:0] ERR_REFUSED = 8'h03;

  // Sizes and limits
  localparam logic [8:0] FIFO_PEN_BLOCKS = 9'h0F0;
  localparam logic [8:0] FIFO_DOT_BLOCKS = 9'h03C;
  localparam logic [3:0] RETX_LIMIT      = 4'hE;
  localparam logic [7:0] UNIT_ADDR_MIN   = 8'h01;
  localparam logic [7:0] UNIT_ADDR_MAX   = 8'h20;
  localparam logic [7:0] CHAR_ESC        = 8'h1B;
  localparam logic [7:0] CHAR_OPEN       = 8'h4F;
  localparam logic [7:0] CHAR_CLOSE      = 8'h43;
  localparam logic [3:0] HEADER_TAG      = 4'hF;

  // Server ports that the maintenance close must not touch
  localparam logic [15:0] SRV_PORT_A = 16'h8566;
  localparam logic [15:0] SRV_PORT_B = 16'h856B;
  localparam logic [15:0] SRV_PORT_C = 16'h856F;

  typedef enum logic [3:0] {
    OP_BYTE_ORDER, OP_CHECKSUM, OP_STATUS_MASK, OP_STATUS_REPORT,
    OP_LINK_DROP, OP_SETUP_DUMP, OP_LATEST_SAMPLE, OP_PERIODIC_PRINT,
    OP_FIFO_OUTPUT, OP_USER_REPORT, OP_UNIT_OPEN, OP_UNIT_CLOSE,
    OP_LEAVE_BASIC_DROP, OP_MAINT_CLOSE
  } rocu_op_e;

  typedef enum logic [1:0] {
    FOP_LOG_READ, FOP_REPEAT_LAST, FOP_REWIND, FOP_NEWEST_READ
  } rocu_fop_e;

  typedef enum logic [1:0] {
    ST_IDLE, ST_HEAD, ST_ITEMS
  } rocu_state_e;

endpackage

/* File: rtl/rocu_core.sv */
// Output command interpreter with session settings, FIFO and link control
//
// Notes on behaviour
// - Byte order 0 MSB first, 1 LSB first.
// - Checksum on/off, serial interface only.
// - Stored status mask filters status report.
// - Serial reset/dropping exit restores defaults.
// - Ethernet disconnect restores byte order, mask.
// - Link drop closes the Ethernet connection.
// - Setup dump type 0,1,2,4 over channel range.
// - Latest sample, type 0 ASCII else binary.
// - Periodic print momentary values per channel.
// - FIFO log, repeat, rewind, newest operations.
// - Block limit 1-240 pen, 1-60 dot.
// - Circular FIFO of 240/60 blocks overwrites oldest.
// - Newest read counts back from acquire position.
// - Range, count only for log/newest; omitted means all.
// - Unit open 01-32, one open, echo.
// - Unit close 01-32 ends connection, echo.
// - User report outputs connected user info.
// - Maintenance close refuses server, own connection.
// - Fifteen unanswered retransmission expiries drop the connection.
// - Success answers E0, failure an error number.
`timescale 1ns/1ns
module rocu_core
  import rocu_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Measurement acquisition
  input  wire logic        acq_valid,
  input  wire logic [31:0] acq_data,
  // Instrument state sources
  input  wire logic [31:0] status_in,
  input  wire logic [31:0] user_info,
  // Ethernet connection events
  input  wire logic        link_down,
  input  wire logic        retx_expire,
  input  wire logic        seg_acked,
  // Response stream
  output logic             tx_valid,
  output logic      [31:0] tx_data,
  output logic             tx_last,
  input  wire logic        tx_ready,
  // Connection control
  output logic             link_drop,
  output logic             conn_close,
  output logic      [15:0] close_local_port,
  output logic      [31:0] close_remote_ip,
  output logic      [15:0] close_remote_port,
  output logic             unit_open
);

  logic [31:0] arg0_q, arg1_q, iface_q, own_conn_q, own_ip_q, mask_q, drops_q;
  logic        bo_q, cs_q, ack_q, done_q;
  logic [7:0]  res_q;
  logic [31:0] rdata_q;
  rocu_state_e state_q;
  rocu_op_e    op_q;
  logic [7:0]  p1_q, cur_q, first_q, last_q;
  logic [8:0]  left_q;
  logic [31:0] txd_q;
  logic [31:0] mem [0:239];
  logic [7:0]  wr_ptr_q, rep_start_q, rep_first_q, rep_last_q;
  logic [8:0]  fill_q, avail_q, rep_n_q;
  logic [3:0]  retx_q;
  logic        drop_q, close_q;

  // Bus access strobes; wr and go taken on the edge where the master sees ack, rd_req on the edge before
  logic wr, rd_req, go;
  assign wr     = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
  assign rd_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign go     = wr & (wb_adr_i == REG_CMD) & (state_q == ST_IDLE);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  // Argument fields
  logic       eth, dot, cnt_given, range_ok;
  logic [7:0] p1, first, last, req_cnt, own_addr;
  logic [8:0] cap;
  assign eth       = iface_q[IFACE_ETH_BIT];
  assign dot       = iface_q[IFACE_DOT_BIT];
  assign own_addr  = iface_q[IFACE_ADDR_LSB +: 8];
  assign p1        = arg0_q[7:0];
  assign first     = arg1_q[ARG1_FIRST_LSB +: 8];
  assign last      = arg1_q[ARG1_LAST_LSB +: 8];
  assign req_cnt   = arg1_q[ARG1_COUNT_LSB +: 8];
  assign cnt_given = arg1_q[ARG1_COUNT_GIVEN];
  assign range_ok  = (last >= first);
  assign cap       = dot ? FIFO_DOT_BLOCKS : FIFO_PEN_BLOCKS;

  function automatic logic [7:0] back(input logic [7:0] a, input logic [8:0] n, input logic [8:0] c);
    logic [8:0] s;
    s = {1'b0, a} + c - n;
    if (s >= c) s = s - c;
    return s[7:0];
  endfunction

  // Command decode
  rocu_op_e   op;
  rocu_fop_e  fop;
  logic [7:0] res;
  logic       set_bo, set_cs, set_mask, ser_revert, drop_cmd, close_cmd;
  logic       open_set, open_clr, st_head, st_item, rewind;
  logic [8:0] n_items, log_n, new_n;
  logic [7:0] start_ptr;
  logic [31:0] item0;
  logic       port_refused, addr_ok, lim_ok;

  assign op  = rocu_op_e'(wb_dat_i[3:0]);
  assign fop = rocu_fop_e'(p1[1:0]);
  assign addr_ok = (p1 >= UNIT_ADDR_MIN) && (p1 <= UNIT_ADDR_MAX) && !arg0_q[ARG0_LF_ONLY_BIT];
  assign lim_ok  = !cnt_given || ((req_cnt != 8'h00) && ({1'b0, req_cnt} <= cap));
  assign log_n   = (cnt_given && ({1'b0, req_cnt} < avail_q)) ? {1'b0, req_cnt} : avail_q;
  assign new_n   = (cnt_given && ({1'b0, req_cnt} < fill_q)) ? {1'b0, req_cnt} : fill_q;
  assign port_refused = (arg0_q[31:16] == SRV_PORT_A) || (arg0_q[31:16] == SRV_PORT_B) ||
                        (arg0_q[31:16] == SRV_PORT_C) ||
                        ((arg0_q == own_conn_q) && (arg1_q == own_ip_q));

  always_comb begin
    res = RESP_OK;
    set_bo = 1'b0; set_cs = 1'b0; set_mask = 1'b0; ser_revert = 1'b0;
    drop_cmd = 1'b0; close_cmd = 1'b0; open_set = 1'b0; open_clr = 1'b0;
    st_head = 1'b0; st_item = 1'b0; rewind = 1'b0;
    n_items = 9'h000; start_ptr = 8'h00; item0 = 32'h00000000;
    unique case (op)
      OP_BYTE_ORDER: if (p1 > 8'h01) res = ERR_PARAM; else set_bo = 1'b1;
      OP_CHECKSUM: begin
        if (eth) res = ERR_IFACE;
        else if (p1 > 8'h01) res = ERR_PARAM;
        else set_cs = 1'b1;
      end
      OP_STATUS_MASK: set_mask = 1'b1;
      OP_STATUS_REPORT: begin
        if (p1 != 8'h00) res = ERR_PARAM;
        else begin st_item = 1'b1; n_items = 9'h001; item0 = status_in & mask_q; end
      end
      OP_LINK_DROP: begin
        if (p1 != 8'h00) res = ERR_PARAM;
        else if (!eth) res = ERR_IFACE;
        else drop_cmd = 1'b1;
      end
      OP_SETUP_DUMP: begin
        if (!(p1 inside {8'h00, 8'h01, 8'h02, 8'h04}) || !range_ok) res = ERR_PARAM;
        else begin st_head = 1'b1; n_items = 9'(last - first) + 9'h001; start_ptr = first; end
      end
      OP_LATEST_SAMPLE: begin
        if (p1 > 8'h01 || !range_ok) res = ERR_PARAM;
        else begin st_head = 1'b1; n_items = 9'(last - first) + 9'h001; start_ptr = first; end
      end
      OP_PERIODIC_PRINT: begin
        if (p1 != 8'h00 || !range_ok) res = ERR_PARAM;
        else begin st_head = 1'b1; n_items = 9'(last - first) + 9'h001; start_ptr = first; end
      end
      OP_FIFO_OUTPUT: begin
        unique case (fop)
          FOP_LOG_READ: begin
            if (!range_ok || !lim_ok) res = ERR_PARAM;
            else begin st_head = 1'b1; n_items = log_n; start_ptr = back(wr_ptr_q, avail_q, cap); end
          end
          FOP_NEWEST_READ: begin
            if (!range_ok || !lim_ok) res = ERR_PARAM;
            else begin st_head = 1'b1; n_items = new_n; start_ptr = back(wr_ptr_q, new_n, cap); end
          end
          FOP_REPEAT_LAST: begin st_head = 1'b1; n_items = rep_n_q; start_ptr = rep_start_q; end
          FOP_REWIND: rewind = 1'b1;
        endcase
      end
      OP_USER_REPORT: begin
        if (p1 != 8'h00) res = ERR_PARAM;
        else begin st_item = 1'b1; n_items = 9'h001; item0 = user_info; end
      end
      OP_UNIT_OPEN: begin
        if (eth) res = ERR_IFACE;
        else if (!addr_ok) res = ERR_PARAM;
        else if (p1 == own_addr) begin
          open_set = 1'b1; st_item = 1'b1; n_items = 9'h001;
          item0 = {8'h00, CHAR_ESC, CHAR_OPEN, own_addr};
        end else begin
          open_clr = 1'b1; res = RESP_NONE;
        end
      end
      OP_UNIT_CLOSE: begin
        if (eth) res = ERR_IFACE;
        else if (!addr_ok) res = ERR_PARAM;
        else if (p1 == own_addr) begin
          open_clr = 1'b1; st_item = 1'b1; n_items = 9'h001;
          item0 = {8'h00, CHAR_ESC, CHAR_CLOSE, own_addr};
        end else res = RESP_NONE;
      end
      OP_LEAVE_BASIC_DROP: begin
        if (eth) drop_cmd = 1'b1;
        else ser_revert = 1'b1;
      end
      OP_MAINT_CLOSE: begin
        if (!eth) res = ERR_IFACE;
        else if (port_refused) res = ERR_REFUSED;
        else close_cmd = 1'b1;
      end
      default: res = ERR_PARAM;
    endcase
  end

  // Wishbone ack and read data
  always_ff @(posedge clk) begin
    if (srst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= rd_req;
      if (rd_req) begin
        unique case (wb_adr_i)
          REG_ARG0:     rdata_q <= arg0_q;
          REG_ARG1:     rdata_q <= arg1_q;
          REG_RESULT:   rdata_q <= {22'h0, state_q != ST_IDLE, done_q, res_q};
          REG_SETTINGS: rdata_q <= {29'h0, unit_open, cs_q, bo_q};
          REG_MASK:     rdata_q <= mask_q;
          REG_IFACE:    rdata_q <= iface_q;
          REG_OWN_CONN: rdata_q <= own_conn_q;
          REG_OWN_IP:   rdata_q <= own_ip_q;
          REG_DROPS:    rdata_q <= drops_q;
          default:      rdata_q <= 32'h00000000;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // Software written configuration
  always_ff @(posedge clk) begin
    if (srst) begin
      arg0_q     <= 32'h00000000;
      arg1_q     <= 32'h00000000;
      iface_q    <= 32'h00000000;
      own_conn_q <= 32'h00000000;
      own_ip_q   <= 32'h00000000;
    end else if (wr) begin
      if (wb_adr_i == REG_ARG0)     arg0_q     <= merge(arg0_q, wb_dat_i, wb_sel_i);
      if (wb_adr_i == REG_ARG1)     arg1_q     <= merge(arg1_q, wb_dat_i, wb_sel_i);
      if (wb_adr_i == REG_IFACE)    iface_q    <= merge(iface_q, wb_dat_i, wb_sel_i);
      if (wb_adr_i == REG_OWN_CONN) own_conn_q <= merge(own_conn_q, wb_dat_i, wb_sel_i);
      if (wb_adr_i == REG_OWN_IP)   own_ip_q   <= merge(own_ip_q, wb_dat_i, wb_sel_i);
    end
  end

  // Session settings; rejected commands leave them untouched
  logic to_drop, eth_revert;
  assign to_drop    = retx_expire && !seg_acked && (retx_q == RETX_LIMIT);
  assign eth_revert = link_down | drop_q;
  always_ff @(posedge clk) begin
    if (srst || (go && ser_revert)) begin
      bo_q   <= BYTE_ORDER_RST;
      cs_q   <= CHECKSUM_RST;
      mask_q <= MASK_RST;
    end else if (eth_revert) begin
      bo_q   <= BYTE_ORDER_RST;
      mask_q <= MASK_RST;
    end else if (go) begin
      if (set_bo)   bo_q   <= p1[0];
      if (set_cs)   cs_q   <= p1[0];
      if (set_mask) mask_q <= arg0_q;
    end
  end

  // Result of the last command
  always_ff @(posedge clk) begin
    if (srst) begin
      res_q  <= RESP_NONE;
      done_q <= 1'b0;
    end else if (go) begin
      res_q  <= res;
      done_q <= 1'b1;
    end
  end

  // Unit addressing on the multidrop line
  always_ff @(posedge clk) begin
    if (srst) unit_open <= 1'b0;
    else if (go && open_set) unit_open <= 1'b1;
    else if (go && open_clr) unit_open <= 1'b0;
  end

  // Connection drop and maintenance close
  always_ff @(posedge clk) begin
    if (srst) begin
      drop_q            <= 1'b0;
      close_q           <= 1'b0;
      close_local_port  <= 16'h0000;
      close_remote_port <= 16'h0000;
      close_remote_ip   <= 32'h00000000;
    end else begin
      drop_q  <= (go && drop_cmd) || to_drop;
      close_q <= go && close_cmd;
      if (go && close_cmd) begin
        close_local_port  <= arg0_q[31:16];
        close_remote_port <= arg0_q[15:0];
        close_remote_ip   <= arg1_q;
      end
    end
  end
  assign link_drop  = drop_q;
  assign conn_close = close_q;

  // Retransmission watch
  always_ff @(posedge clk) begin
    if (srst) begin
      retx_q  <= 4'h0;
      drops_q <= 32'h00000000;
    end else if (seg_acked || link_down) begin
      retx_q <= 4'h0;
    end else if (retx_expire) begin
      if (retx_q == RETX_LIMIT) begin
        retx_q  <= 4'h0;
        drops_q <= drops_q + 32'h00000001;
      end else begin
        retx_q <= retx_q + 4'h1;
      end
    end
  end

  // Circular measurement FIFO
  logic       log_take;
  logic [8:0] avail_n;
  assign log_take = go && (op == OP_FIFO_OUTPUT) && (fop == FOP_LOG_READ) && st_head;
  assign avail_n  = rewind && go && (op == OP_FIFO_OUTPUT) ? 9'h000 : (log_take ? avail_q - log_n : avail_q);
  always_ff @(posedge clk) begin
    if (acq_valid) mem[wr_ptr_q] <= acq_data;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_q <= 8'h00;
      fill_q   <= 9'h000;
      avail_q  <= 9'h000;
    end else begin
      if (acq_valid) begin
        wr_ptr_q <= ({1'b0, wr_ptr_q} + 9'h001 >= cap) ? 8'h00 : wr_ptr_q + 8'h01;
        if (fill_q < cap) fill_q <= fill_q + 9'h001;
      end
      avail_q <= (acq_valid && avail_n < cap) ? avail_n + 9'h001 : avail_n;
    end
  end

  // Repeat-last memory of the previous FIFO output
  always_ff @(posedge clk) begin
    if (srst) begin
      rep_start_q <= 8'h00;
      rep_n_q     <= 9'h000;
      rep_first_q <= 8'h00;
      rep_last_q  <= 8'h00;
    end else if (go && (op == OP_FIFO_OUTPUT) && st_head && (fop != FOP_REPEAT_LAST)) begin
      rep_start_q <= start_ptr;
      rep_n_q     <= n_items;
      rep_first_q <= first;
      rep_last_q  <= last;
    end
  end

  // Response stream
  function automatic logic [31:0] item_word(input rocu_op_e o, input logic [7:0] t, input logic [7:0] i);
    if (o == OP_FIFO_OUTPUT) return mem[i];
    return {4'h0, o, t, 8'h00, i};
  endfunction

  logic [7:0] nxt_cur, hdr_first, hdr_last;
  logic       rep_hdr;
  assign nxt_cur   = (op_q == OP_FIFO_OUTPUT && {1'b0, cur_q} + 9'h001 >= cap) ? 8'h00 : cur_q + 8'h01;
  assign rep_hdr   = (op == OP_FIFO_OUTPUT) && (fop == FOP_REPEAT_LAST);
  assign hdr_first = rep_hdr ? rep_first_q : first;
  assign hdr_last  = rep_hdr ? rep_last_q : last;

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      op_q    <= OP_BYTE_ORDER;
      p1_q    <= 8'h00;
      cur_q   <= 8'h00;
      left_q  <= 9'h000;
      txd_q   <= 32'h00000000;
    end else begin
      unique case (state_q)
        ST_IDLE: if (go && (st_head || st_item)) begin
          op_q   <= op;
          p1_q   <= p1;
          cur_q  <= start_ptr;
          left_q <= n_items;
          if (st_head) begin
            state_q <= ST_HEAD;
            txd_q   <= {HEADER_TAG, op, 6'h00, cs_q, bo_q, hdr_first, hdr_last};
          end else begin
            state_q <= ST_ITEMS;
            txd_q   <= item0;
          end
        end
        ST_HEAD: if (tx_ready) begin
          if (left_q == 9'h000) state_q <= ST_IDLE;
          else begin
            state_q <= ST_ITEMS;
            txd_q   <= item_word(op_q, p1_q, cur_q);
          end
        end
        ST_ITEMS: if (tx_ready) begin
          if (left_q == 9'h001) state_q <= ST_IDLE;
          else begin
            left_q <= left_q - 9'h001;
            cur_q  <= nxt_cur;
            txd_q  <= item_word(op_q, p1_q, nxt_cur);
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  assign tx_valid = (state_q != ST_IDLE);
  assign tx_data  = txd_q;
  assign tx_last  = ((state_q == ST_HEAD) && (left_q == 9'h000)) || ((state_q == ST_ITEMS) && (left_q == 9'h001));

endmodule // rocu_core

/* File: tb/rocu_core_monitor.sv */
// Concurrent checks on the ports of the output command unit
`timescale 1ns/1ns
module rocu_core_monitor
  import rocu_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Register bus
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  // Events, stream and control
  input wire logic        retx_expire,
  input wire logic        tx_valid,
  input wire logic [31:0] tx_data,
  input wire logic        tx_last,
  input wire logic        tx_ready,
  input wire logic        link_drop,
  input wire logic        conn_close,
  input wire logic [15:0] close_local_port,
  input wire logic        unit_open
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic cmd_q;
  logic open_q;
  logic retx_q;
  // Command write and expiry seen one edge back
  always_ff @(posedge clk) begin
    cmd_q  <= wb_ack_o && wb_we_i && wb_adr_i == REG_CMD;
    open_q <= wb_ack_o && wb_we_i && wb_adr_i == REG_CMD && wb_dat_i[3:0] == 4'hA;
    retx_q <= retx_expire;
  end
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
  endproperty
  a_hold: assert property (p_hold) else $error("stream word left early");
  property p_dpulse;
    link_drop |=> !link_drop;
  endproperty
  a_dpulse: assert property (p_dpulse) else $error("drop pulse too long");
  property p_drop;
    link_drop |-> cmd_q || retx_q || $past(cmd_q) || $past(retx_q);
  endproperty
  a_drop: assert property (p_drop) else $error("drop without cause");
  property p_cpulse;
    conn_close |=> !conn_close;
  endproperty
  a_cpulse: assert property (p_cpulse) else $error("close pulse too long");
  property p_srv;
    conn_close |-> close_local_port != SRV_PORT_A && close_local_port != SRV_PORT_B
      && close_local_port != SRV_PORT_C;
  endproperty
  a_srv: assert property (p_srv) else $error("server port closed");
  property p_open;
    $rose(unit_open) |-> open_q;
  endproperty
  a_open: assert property (p_open) else $error("unit opened without command");
  property p_shut;
    $fell(unit_open) |-> cmd_q;
  endproperty
  a_shut: assert property (p_shut) else $error("unit closed without command");
  property p_rst;
    $fell(srst) |-> !unit_open && !tx_valid && !link_drop && !conn_close;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule // rocu_core_monitor

/* File: tb/rocu_host_model.sv */
// Host side of the response stream, taking words with random stalls
`timescale 1ns/1ns
module rocu_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Response stream
  output logic     tx_ready
);
  // Stalls prove that each word stands until taken
  always @(posedge clk) begin
    tx_ready <= !srst && ($urandom % 4) != 0;
  end
endmodule // rocu_host_model

/* File: tb/testbench.sv */
// Self-checking bench of the output command unit
`timescale 1ns/1ns
module testbench;
  import rocu_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic        acq_valid = 1'b0, link_down = 1'b0, retx_expire = 1'b0, seg_acked = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, acq_data = 32'h0, status_in = 32'h0, user_info = 32'h0;
  logic [31:0] wb_dat_o, tx_data, c_ip, m, r, blk [3];
  logic [15:0] c_lp, c_rp;
  logic        wb_ack_o, tx_valid, tx_last, tx_ready, link_drop, conn_close, unit_open;
  logic [32:0] exq [$];
  logic [11:0] ty [7] = '{12'h500, 12'h501, 12'h502, 12'h504, 12'h600, 12'h601, 12'h700};
  int          n_fail = 0, n_tests = 0, n_drop = 0;
  rocu_core u_rocu_core (.clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
    .wb_sel_i, .wb_dat_o, .wb_ack_o, .acq_valid, .acq_data, .status_in, .user_info, .link_down,
    .retx_expire, .seg_acked, .tx_valid, .tx_data, .tx_last, .tx_ready, .link_drop, .conn_close,
    .close_local_port(c_lp), .close_remote_ip(c_ip), .close_remote_port(c_rp), .unit_open);
  rocu_host_model u_rocu_host_model (.clk, .srst, .tx_ready);
  always #5 clk = ~clk;
  task automatic chk(input string s, input logic [32:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    r = wb_dat_o;
    chk("ack", 1, wb_ack_o);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input string s, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(s, e, r);
  endtask
  // One command, then wait until its stream has been taken
  task automatic run(input logic [3:0] op, input logic [31:0] a0, a1, input logic [7:0] code);
    int n = 0;
    wb(1'b1, REG_ARG0, a0);
    wb(1'b1, REG_ARG1, a1);
    wb(1'b1, REG_CMD, {28'h0, op});
    wb(1'b0, REG_RESULT, 32'h0);
    chk("result", code, r[7:0]);
    while ((tx_valid !== 1'b0 || exq.size() != 0) && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk("drained", 0, exq.size());
  endtask
  function automatic logic [32:0] hd(input logic [3:0] op, input logic [1:0] sb, input logic [7:0] f, l,
                                     input logic z);
    return {z, 4'hF, op, 6'h0, sb, f, l};
  endfunction
  task automatic chan(input logic [3:0] op, input logic [7:0] p, f, l, input logic [1:0] sb);
    exq.push_back(hd(op, sb, f, l, 1'b0));
    for (logic [7:0] c = f; c <= l; c++) exq.push_back({c == l, 4'h0, op, p, 8'h00, c});
    run(op, {24'h0, p}, {16'h0, l, f}, RESP_OK);
  endtask
  task automatic ff(input logic [1:0] op, input logic [8:0] cnt, input int k, n, input logic [7:0] code);
    if (code == RESP_OK && op != 2'd2) exq.push_back(hd(4'h8, 2'b00, 8'd1, 8'd6, n == 0));
    for (int i = k; i < k + n; i++) exq.push_back({i == k + n - 1, blk[i]});
    run(4'h8, {30'h0, op}, {7'h0, cnt, 8'd6, 8'd1}, code);
  endtask
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (exq.size() == 0) chk("stray word", 0, 1);
      else chk("stream", exq.pop_front(), {tx_last, tx_data});
    end
    if (link_drop === 1'b1) n_drop++;
  end
  initial begin
    #500000;
    n_fail++;
    results();
  end
  initial begin
    void'($urandom(32'h49FACF50));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd("settings", REG_SETTINGS, 32'h0);
    rd("mask", REG_MASK, MASK_RST);
    rd("unmapped", 8'h3C, 32'h0);
    run(4'h0, 32'h1, 32'h0, RESP_OK);
    run(4'h0, 32'h2, 32'h0, ERR_PARAM);
    run(4'h1, 32'h1, 32'h0, RESP_OK);
    rd("settings", REG_SETTINGS, 32'h3);
    m = $urandom;
    run(4'h2, m, 32'h0, RESP_OK);
    rd("mask", REG_MASK, m);
    status_in <= $urandom;
    @(posedge clk);
    exq.push_back({1'b1, status_in & m});
    run(4'h3, 32'h0, 32'h0, RESP_OK);
    chan(4'h6, 8'h01, 8'd1, 8'd2, 2'b11);
    wb(1'b1, REG_IFACE, 32'h0500);
    exq.push_back({1'b1, 32'h001B4F05});
    run(4'hA, 32'h5, 32'h0, RESP_OK);
    rd("settings", REG_SETTINGS, 32'h7);
    exq.push_back({1'b1, 32'h001B4305});
    run(4'hB, 32'h5, 32'h0, RESP_OK);
    rd("settings", REG_SETTINGS, 32'h3);
    run(4'hA, 32'h21, 32'h0, ERR_PARAM);
    run(4'hA, 32'h105, 32'h0, ERR_PARAM);
    exq.push_back({1'b1, 32'h001B4F05});
    run(4'hA, 32'h5, 32'h0, RESP_OK);
    run(4'hA, 32'h6, 32'h0, RESP_NONE);
    rd("settings", REG_SETTINGS, 32'h3);
    run(4'hC, 32'h0, 32'h0, RESP_OK);
    rd("settings", REG_SETTINGS, 32'h0);
    rd("mask", REG_MASK, MASK_RST);
    foreach (ty[i]) chan(ty[i][11:8], ty[i][7:0], 8'd1, 8'd1 + 8'($urandom % 3), 2'b00);
    run(4'h6, 32'h0, {16'h0, 8'd1, 8'd3}, ERR_PARAM);
    run(4'hE, 32'h0, 32'h0, ERR_PARAM);
    for (int i = 0; i < 3; i++) begin
      blk[i] = $urandom;
      acq_valid <= 1'b1;
      acq_data <= blk[i];
      @(posedge clk);
    end
    acq_valid <= 1'b0;
    @(posedge clk);
    ff(2'd0, 9'h102, 0, 2, RESP_OK);
    ff(2'd1, 9'h102, 0, 2, RESP_OK);
    ff(2'd3, 9'h1F0, 0, 3, RESP_OK);
    ff(2'd3, 9'h102, 1, 2, RESP_OK);
    ff(2'd3, 9'h000, 0, 3, RESP_OK);
    ff(2'd2, 9'h000, 0, 0, RESP_OK);
    ff(2'd0, 9'h000, 0, 0, RESP_OK);
    ff(2'd0, 9'h1F1, 0, 0, ERR_PARAM);
    ff(2'd0, 9'h100, 0, 0, ERR_PARAM);
    wb(1'b1, REG_IFACE, 32'h2);
    ff(2'd0, 9'h13D, 0, 0, ERR_PARAM);
    ff(2'd0, 9'h13C, 0, 0, RESP_OK);
    wb(1'b1, REG_IFACE, 32'h1);
    run(4'h1, 32'h1, 32'h0, ERR_IFACE);
    run(4'h0, 32'h1, 32'h0, RESP_OK);
    run(4'h2, 32'h0, 32'h0, RESP_OK);
    link_down <= 1'b1;
    @(posedge clk);
    link_down <= 1'b0;
    @(posedge clk);
    rd("settings", REG_SETTINGS, 32'h0);
    rd("mask", REG_MASK, MASK_RST);
    run(4'h4, 32'h0, 32'h0, RESP_OK);
    chk("drops", 1, n_drop);
    user_info <= $urandom;
    @(posedge clk);
    exq.push_back({1'b1, user_info});
    run(4'h9, 32'h0, 32'h0, RESP_OK);
    wb(1'b1, REG_OWN_CONN, 32'h03E8041E);
    wb(1'b1, REG_OWN_IP, 32'hC0A80001);
    run(4'hD, {SRV_PORT_C, 16'h041E}, 32'hC0A80002, ERR_REFUSED);
    run(4'hD, 32'h03E8041E, 32'hC0A80001, ERR_REFUSED);
    run(4'hD, 32'h03E8041F, 32'hC0A80002, RESP_OK);
    chk("close ports", {1'b0, 32'h03E8041F}, {1'b0, c_lp, c_rp});
    chk("close ip", 32'hC0A80002, c_ip);
    for (int i = 0; i < 30; i++) begin
      retx_expire <= i != 14 && i < 29;
      seg_acked <= i == 14;
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
    chk("no drop", 1, n_drop);
    rd("drop count", REG_DROPS, 32'h0);
    retx_expire <= 1'b1;
    @(posedge clk);
    retx_expire <= 1'b0;
    repeat (3) @(posedge clk);
    chk("timeout drop", 2, n_drop);
    rd("drop count", REG_DROPS, 32'h1);
    results();
  end
endmodule // testbench
bind rocu_core rocu_core_monitor u_rocu_core_monitor (.clk, .srst, .wb_we_i, .wb_adr_i, .wb_dat_i,
  .wb_ack_o, .retx_expire, .tx_valid, .tx_data, .tx_last, .tx_ready, .link_drop, .conn_close,
  .close_local_port, .unit_open);
